// ### include/smc_defs.svh
// Register offsets, field positions and reset values of the serial core.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Register word addresses.
`define SMC_ADDR_CTRL1 3'h0
`define SMC_ADDR_CTRL2 3'h1
`define SMC_ADDR_BAUD 3'h2
`define SMC_ADDR_STATUS 3'h3
`define SMC_ADDR_DATA 3'h4

// Main control register bit positions.
`define SMC_C1_RXIE 7
`define SMC_C1_EN 6
`define SMC_C1_TXIE 5
`define SMC_C1_ROLE 4
`define SMC_C1_POL 3
`define SMC_C1_PHA 2
`define SMC_C1_SELECT_OUTPUT_ENABLE 1
`define SMC_C1_LSBF 0

// Second control register bit positions and implemented-bit mask.
`define SMC_C2_FAULT_EN 4
`define SMC_C2_PIN_OE 3
`define SMC_C2_SINGLE 0
`define SMC_C2_MASK 8'h19

// Baud register fields and implemented-bit mask.
`define SMC_BR_PRE_HI 6
`define SMC_BR_PRE_LO 4
`define SMC_BR_RATE_HI 2
`define SMC_BR_RATE_LO 0
`define SMC_BR_MASK 8'h77

// Status register bit positions.
`define SMC_ST_RXF 7
`define SMC_ST_TXE 5
`define SMC_ST_MODE_FAULT_FLAG 4

// Reset values.
`define SMC_CTRL1_RST 8'h04
`define SMC_CTRL2_RST 8'h00
`define SMC_BAUD_RST 8'h00
`define SMC_SYNC_RST 4'h8

// Last serial clock edge of a byte (sixteen edges, counted from zero).
`define SMC_EDGE_LAST 4'hF

`endif

// ### include/smc_pkg.sv
// Types shared by the serial core: engine states, bus request, pin bundle.
// Assumes smc_defs.svh supplies every number.
package smc_pkg;

  // Engine state: waiting for a start, or shifting a byte.
  typedef enum logic [0:0] {SMC_IDLE, SMC_RUN} smc_state_t;

  // One register port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smc_bus_t;

  // Registered pin drive; each enable is active low.
  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic mdp_o;
    logic mdp_oe_n;
    logic sdp_o;
    logic sdp_oe_n;
    logic sel_o;
    logic sel_oe_n;
  } smc_pins_t;

endpackage

// ### hdl/smc_core.sv
// Byte-wide serial peripheral engine, master or slave, with register port.
// Assumes a 100 MHz system clock, synchronous active-low reset, and pad
// logic outside that turns each output/enable pair into a real pin.
//
// Contract
// - Master starts transfers, exchanges shifter contents.
// - Data write buffered, loaded at transfer start.
// - Received byte copied to receive buffer.
// - Master drives clock, data out, samples in.
// - Slave takes clock, drives slave line.
// - Prescaler divides bus clock by 1..8.
// - Rate divider divides by 2..256.
// - Disabled block releases all four pins.
// - Master single-wire uses master pin only.
// - Slave single-wire uses slave pin only.
// - Select pin role from fault and output enables.
// - Stop modes: inactive, deep resets, light holds.
// - Light stop exit resumes, reset exit resets.
// - Bit 7 gates receive/fault interrupt.
// - Disable aborts, flushes, clears receive, sets empty.
// - Bit 5 gates transmit-empty interrupt.
// - Bit 4 selects slave or master.
// - Bit 3 sets serial clock idle level.
// - Bit 2 places first edge mid or start.
// - Bit 0 picks MSB or LSB first.
//
// The plain strobed port and the register addresses are this design's own decisions.
`include "smc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module smc_core
  import smc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_STOP_DEEP,
  input wire logic I_STOP_LIGHT,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  input wire logic I_SERIAL_CLOCK_PIN,
  output logic O_SERIAL_CLOCK_PIN,
  output logic O_SERIAL_CLOCK_PIN_OE_N,
  input wire logic I_MASTER_SHARED_DATA_PIN,
  output logic O_MASTER_SHARED_DATA_PIN,
  output logic O_MASTER_SHARED_DATA_PIN_OE_N,
  input wire logic I_SLAVE_SHARED_DATA_PIN,
  output logic O_SLAVE_SHARED_DATA_PIN,
  output logic O_SLAVE_SHARED_DATA_PIN_OE_N,
  input wire logic I_SELECT_PIN,
  output logic O_SELECT_PIN,
  output logic O_SELECT_PIN_OE_N
);

  // ==========================================================================
  // Helpers
  // ==========================================================================

  // Register decode, shared by every strobe.
  function automatic logic hit(input logic [2:0] a, input logic [2:0] t, input logic s);
    hit = s && (a == t);
  endfunction

  // First bit to leave the shifter for the chosen bit order.
  function automatic logic head(input logic [7:0] sh, input logic lsb);
    head = lsb ? sh[0] : sh[7];
  endfunction

  // ==========================================================================
  // Reset, bus request and configuration fields
  // ==========================================================================

  // Deep stop removes power, so it behaves like a reset on return.
  logic rst; // Combined synchronous reset.
  assign rst = !I_RESETN || I_STOP_DEEP;

  smc_bus_t bus; // Port request bundled for decode.
  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  logic [7:0] ctrl1; // Main control register.
  logic [7:0] ctrl2; // Pin control register.
  logic [7:0] baud; // Prescale and rate fields.

  logic en, role, clk_pol, clk_pha, select_output_enable, lsbf, rxie, txie;
  logic fault_en, pin_oe, single;
  logic [2:0] pre_sel, rate_sel;
  assign en = ctrl1[`SMC_C1_EN];
  assign role = ctrl1[`SMC_C1_ROLE];
  assign clk_pol = ctrl1[`SMC_C1_POL];
  assign clk_pha = ctrl1[`SMC_C1_PHA];
  assign select_output_enable = ctrl1[`SMC_C1_SELECT_OUTPUT_ENABLE];
  assign lsbf = ctrl1[`SMC_C1_LSBF];
  assign rxie = ctrl1[`SMC_C1_RXIE];
  assign txie = ctrl1[`SMC_C1_TXIE];
  assign fault_en = ctrl2[`SMC_C2_FAULT_EN];
  assign pin_oe = ctrl2[`SMC_C2_PIN_OE];
  assign single = ctrl2[`SMC_C2_SINGLE];
  assign pre_sel = baud[`SMC_BR_PRE_HI:`SMC_BR_PRE_LO];
  assign rate_sel = baud[`SMC_BR_RATE_HI:`SMC_BR_RATE_LO];

  // The block does nothing while disabled or in light stop.
  logic active;
  assign active = en && !I_STOP_LIGHT;

  logic wr_c1, wr_c2, wr_br, wr_dat, rd_sts, rd_dat;
  assign wr_c1 = hit(bus.addr, `SMC_ADDR_CTRL1, bus.wr);
  assign wr_c2 = hit(bus.addr, `SMC_ADDR_CTRL2, bus.wr);
  assign wr_br = hit(bus.addr, `SMC_ADDR_BAUD, bus.wr);
  assign wr_dat = hit(bus.addr, `SMC_ADDR_DATA, bus.wr);
  assign rd_sts = hit(bus.addr, `SMC_ADDR_STATUS, bus.rd);
  assign rd_dat = hit(bus.addr, `SMC_ADDR_DATA, bus.rd);

  // Control registers; unimplemented bits are never stored.
  always_ff @(posedge I_SYS_CLK) begin
    if (rst) begin
      ctrl1 <= `SMC_CTRL1_RST;
      ctrl2 <= `SMC_CTRL2_RST;
      baud <= `SMC_BAUD_RST;
    end else begin
      if (wr_c1) begin
        ctrl1 <= bus.wdata;
      end
      if (wr_c2) begin
        ctrl2 <= bus.wdata & `SMC_C2_MASK;
      end
      if (wr_br) begin
        baud <= bus.wdata & `SMC_BR_MASK;
      end
    end
  end

  // ==========================================================================
  // Pin input synchronisers
  // ==========================================================================

  // Pins are asynchronous; each passes two flops before any logic reads it.
  logic [3:0] pin_in;
  wire [3:0] sync;
  assign pin_in = {I_SELECT_PIN, I_SLAVE_SHARED_DATA_PIN, I_MASTER_SHARED_DATA_PIN,
                   I_SERIAL_CLOCK_PIN};
  localparam logic [3:0] SYNC_RST = `SMC_SYNC_RST;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      logic meta_q; // First stage, read only by the second.
      logic sync_q; // Second stage, safe to use.
      always_ff @(posedge I_SYS_CLK) begin
        if (rst) begin
          meta_q <= SYNC_RST[g];
          sync_q <= SYNC_RST[g];
        end else begin
          meta_q <= pin_in[g];
          sync_q <= meta_q;
        end
      end
      assign sync[g] = sync_q;
    end
  endgenerate

  logic s_sck, s_mdp, s_sdp, s_sel;
  assign s_sck = sync[0];
  assign s_mdp = sync[1];
  assign s_sdp = sync[2];
  assign s_sel = sync[3];

  // Delayed copy of the synchronised clock for slave edge detection.
  logic sck_d;
  always_ff @(posedge I_SYS_CLK) begin
    if (rst) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= s_sck;
    end
  end

  // ==========================================================================
  // Engine control terms
  // ==========================================================================

  smc_state_t state; // Engine state.
  logic [3:0] edge_cnt; // Serial clock edges seen in this byte.
  logic [7:0] shifter; // The one shift register for both directions.
  logic out_bit; // Bit presented on the data output.
  logic sck_level; // Master clock phase, zero at idle.
  logic [7:0] tx_buf, rx_buf; // Holding buffers.
  logic tx_empty, rx_full, mode_fault; // Status flags.
  logic half_tick; // Master half bit period elapsed.

  // Master sees a fault when another master pulls its select input low.
  logic fault_cond;
  assign fault_cond = active && role && fault_en && !select_output_enable && !s_sel;

  // Master starts only on its own initiative with a byte waiting.
  logic start, abort, edge_ev, sample, drive, done;
  assign start = active && (state == SMC_IDLE) &&
                 (role ? (!tx_empty && !fault_cond) : !s_sel);
  assign abort = role ? fault_cond : s_sel;
  assign edge_ev = active && (state == SMC_RUN) && !abort &&
                   (role ? half_tick : (s_sck ^ sck_d));
  // Phase 0 samples on even edges, phase 1 on odd ones.
  assign sample = edge_ev && (edge_cnt[0] == clk_pha);
  assign drive = edge_ev && (edge_cnt[0] != clk_pha);
  assign done = edge_ev && (edge_cnt == `SMC_EDGE_LAST);

  // Serial input source by role and wiring mode.
  logic din;
  always_comb begin
    if (role) begin
      din = single ? s_mdp : s_sdp;
    end else begin
      din = single ? s_sdp : s_mdp;
    end
  end

  logic [7:0] next_shift; // Shifter after one sample.
  assign next_shift = lsbf ? {din, shifter[7:1]} : {shifter[6:0], din};

  // An empty buffer leaves the slave resending its last shifter contents.
  logic [7:0] ld_val;
  assign ld_val = tx_empty ? shifter : tx_buf;

  // ==========================================================================
  // Bit rate generator
  // ==========================================================================

  // Prescaler counts 0..pre_sel; the rate stage then counts half periods.
  logic [2:0] pre_cnt;
  logic [6:0] rate_cnt, rate_top;
  assign rate_top = 7'((8'h01 << rate_sel) - 8'h01);
  assign half_tick = (state == SMC_RUN) && role && (pre_cnt == pre_sel) &&
                     (rate_cnt == rate_top);

  always_ff @(posedge I_SYS_CLK) begin
    if (rst || (state != SMC_RUN) || !role) begin
      pre_cnt <= 3'h0;
      rate_cnt <= 7'h00;
    end else if (!I_STOP_LIGHT) begin
      if (pre_cnt == pre_sel) begin
        pre_cnt <= 3'h0;
        rate_cnt <= half_tick ? 7'h00 : 7'(rate_cnt + 7'h01);
      end else begin
        pre_cnt <= 3'(pre_cnt + 3'h1);
      end
    end
  end

  // ==========================================================================
  // Shift engine
  // ==========================================================================

  // Disable clears everything; light stop freezes so the byte resumes later.
  always_ff @(posedge I_SYS_CLK) begin
    if (rst || !en) begin
      state <= SMC_IDLE;
      edge_cnt <= 4'h0;
      shifter <= 8'h00;
      out_bit <= 1'b0;
      sck_level <= 1'b0;
    end else if (!I_STOP_LIGHT) begin
      unique case (state)
        SMC_IDLE: begin
          if (start) begin
            state <= SMC_RUN;
            edge_cnt <= 4'h0;
            sck_level <= 1'b0;
            shifter <= ld_val;
            out_bit <= head(ld_val, lsbf);
          end
        end
        SMC_RUN: begin
          if (abort) begin
            state <= SMC_IDLE;
            sck_level <= 1'b0;
          end else if (edge_ev) begin
            edge_cnt <= 4'(edge_cnt + 4'h1);
            if (role) begin
              sck_level <= !sck_level;
            end
            if (sample) begin
              shifter <= next_shift;
            end
            if (drive) begin
              out_bit <= head(shifter, lsbf);
            end
            if (done) begin
              state <= SMC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Buffers and flags
  // ==========================================================================

  // Each flag clears only after a status read saw it set (armed).
  logic tx_arm, rx_arm, mf_arm;
  logic tx_wr;
  assign tx_wr = wr_dat && tx_arm && tx_empty;

  always_ff @(posedge I_SYS_CLK) begin
    if (rst || !en) begin
      tx_arm <= 1'b0;
      rx_arm <= 1'b0;
    end else begin
      if (rd_sts && tx_empty) begin
        tx_arm <= 1'b1;
      end else if (wr_dat) begin
        tx_arm <= 1'b0;
      end
      if (rd_sts && rx_full) begin
        rx_arm <= 1'b1;
      end else if (rd_dat) begin
        rx_arm <= 1'b0;
      end
    end
  end

  // Transmit side: the load at start empties the buffer and wins over a clear.
  always_ff @(posedge I_SYS_CLK) begin
    if (rst || !en) begin
      tx_empty <= 1'b1;
      tx_buf <= 8'h00;
    end else begin
      if (start && !tx_empty) begin
        tx_empty <= 1'b1;
      end else if (tx_wr) begin
        tx_empty <= 1'b0;
      end
      if (tx_wr) begin
        tx_buf <= bus.wdata;
      end
    end
  end

  // Receive side: a byte arriving while full is dropped, keeping the older one.
  always_ff @(posedge I_SYS_CLK) begin
    if (rst || !en) begin
      rx_full <= 1'b0;
      rx_buf <= 8'h00;
    end else begin
      if (done) begin
        rx_full <= 1'b1;
      end else if (rd_dat && rx_arm) begin
        rx_full <= 1'b0;
      end
      if (done && !rx_full) begin
        rx_buf <= sample ? next_shift : shifter;
      end
    end
  end

  // Mode fault survives disable so software can still see why.
  always_ff @(posedge I_SYS_CLK) begin
    if (rst) begin
      mode_fault <= 1'b0;
      mf_arm <= 1'b0;
    end else begin
      if (fault_cond) begin
        mode_fault <= 1'b1;
      end else if (wr_c1 && mf_arm) begin
        mode_fault <= 1'b0;
      end
      if (rd_sts && mode_fault) begin
        mf_arm <= 1'b1;
      end else if (wr_c1) begin
        mf_arm <= 1'b0;
      end
    end
  end

  // Interrupt request, registered.
  always_ff @(posedge I_SYS_CLK) begin
    if (rst) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= (rxie && (rx_full || mode_fault)) || (txie && tx_empty);
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================

  // Read data stands for the one cycle after the strobe; unmapped reads zero.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `SMC_ADDR_CTRL1: next_rdata = ctrl1;
        `SMC_ADDR_CTRL2: next_rdata = ctrl2;
        `SMC_ADDR_BAUD: next_rdata = baud;
        `SMC_ADDR_STATUS: begin
          next_rdata[`SMC_ST_RXF] = rx_full;
          next_rdata[`SMC_ST_TXE] = tx_empty;
          next_rdata[`SMC_ST_MODE_FAULT_FLAG] = mode_fault;
        end
        `SMC_ADDR_DATA: next_rdata = rx_buf;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (rst) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // Pin multiplexer
  // ==========================================================================

  // Pins are registered so pad drive never glitches on decode changes.
  smc_pins_t next_pins, pins;
  always_comb begin
    next_pins = '{sck_o: 1'b0, sck_oe_n: 1'b1, mdp_o: 1'b0, mdp_oe_n: 1'b1,
                  sdp_o: 1'b0, sdp_oe_n: 1'b1, sel_o: 1'b1, sel_oe_n: 1'b1};
    if (active) begin
      if (role) begin
        next_pins.sck_oe_n = 1'b0;
        next_pins.sck_o = clk_pol ^ sck_level;
        next_pins.mdp_o = out_bit;
        next_pins.mdp_oe_n = single ? !pin_oe : 1'b0;
        if (fault_en && select_output_enable) begin
          next_pins.sel_oe_n = 1'b0;
          next_pins.sel_o = (state != SMC_RUN);
        end
      end else begin
        // Slave drives only while selected, so shared lines stay free.
        next_pins.sdp_o = out_bit;
        next_pins.sdp_oe_n = s_sel || (single && !pin_oe);
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (rst) begin
      pins <= '{sck_o: 1'b0, sck_oe_n: 1'b1, mdp_o: 1'b0, mdp_oe_n: 1'b1,
                sdp_o: 1'b0, sdp_oe_n: 1'b1, sel_o: 1'b1, sel_oe_n: 1'b1};
    end else begin
      pins <= next_pins;
    end
  end

  assign O_SERIAL_CLOCK_PIN = pins.sck_o;
  assign O_SERIAL_CLOCK_PIN_OE_N = pins.sck_oe_n;
  assign O_MASTER_SHARED_DATA_PIN = pins.mdp_o;
  assign O_MASTER_SHARED_DATA_PIN_OE_N = pins.mdp_oe_n;
  assign O_SLAVE_SHARED_DATA_PIN = pins.sdp_o;
  assign O_SLAVE_SHARED_DATA_PIN_OE_N = pins.sdp_oe_n;
  assign O_SELECT_PIN = pins.sel_o;
  assign O_SELECT_PIN_OE_N = pins.sel_oe_n;

  // ==========================================================================
  // Assertions
  // ==========================================================================

  // Cycles since the last half tick, to check the divider chain.
  logic [10:0] gap, half_m1;
  assign half_m1 = 11'(((11'(pre_sel) + 11'h001) << rate_sel) - 11'h001);
  always_ff @(posedge I_SYS_CLK) begin
    if (rst || state != SMC_RUN || half_tick) begin
      gap <= 11'h000;
    end else if (!I_STOP_LIGHT) begin
      gap <= 11'(gap + 11'h001);
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (rst);

  a_disable_flush: assert property (!en |=> tx_empty && !rx_full && state == SMC_IDLE)
    else $error("disable did not flush");
  a_pins_released: assert property (!active |=> pins.sck_oe_n && pins.mdp_oe_n &&
    pins.sdp_oe_n && pins.sel_oe_n) else $error("pins driven while inactive");
  a_master_drive: assert property (active && role && !single |=> !pins.sck_oe_n &&
    !pins.mdp_oe_n && pins.sdp_oe_n) else $error("master pin routing wrong");
  a_slave_route: assert property (active && !role |=>
    pins.sck_oe_n && pins.mdp_oe_n) else $error("slave drove clock or master line");
  a_tx_load: assert property (start && role |=> shifter == $past(tx_buf) && tx_empty)
    else $error("transmit buffer not loaded at start");
  // Phase 0 ends on a drive edge, so the byte is already whole in the shifter.
  a_rx_copy: assert property (done && !rx_full |=> rx_full &&
    rx_buf == ($past(clk_pha) ? $past(next_shift) : $past(shifter)))
    else $error("received byte not captured");
  a_bit_rate: assert property (half_tick |-> gap == half_m1)
    else $error("half bit period wrong");
  a_idle_level: assert property (active && role && state == SMC_IDLE |=>
    pins.sck_o == $past(clk_pol)) else $error("clock idle level wrong");
  a_stop_hold: assert property (I_STOP_LIGHT && en |=> $stable(state) &&
    $stable(edge_cnt) && $stable(shifter)) else $error("engine moved in light stop");
  a_lsb_order: assert property (sample && lsbf |=> shifter[7] == $past(din))
    else $error("low bit first order wrong");
  a_fault_flag: assert property (fault_cond |=> mode_fault && state == SMC_IDLE)
    else $error("mode fault not taken");
  a_irq_gate: assert property ((txie && tx_empty) || (rxie && rx_full) ||
    (rxie && mode_fault) |=> O_IRQ) else $error("interrupt not requested");

  c_master_byte: cover property (done && role);
  c_slave_byte: cover property (done && !role);
  c_mode_fault: cover property (fault_cond);
  c_single_wire: cover property (done && single && role);

endmodule // smc_core

`default_nettype wire

// ### verif/smc_peer.sv
// Model of an external serial slave that faces the core in master role.
// Assumes clock polarity 0 and phase 0, and a pull-up on the select line.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Peer slave
module smc_peer (
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  input wire logic [7:0] i_reply,
  output logic o_miso,
  output logic [7:0] o_got
);
  logic [7:0] sh; // Exchange shifter, filled on each rising clock edge.
  logic out_q; // Bit on the reply line, moved on each falling edge.
  initial begin
    sh = 8'h00;
    out_q = 1'b0;
  end
  // Only a selected peer loads and shifts.
  // Sampling straight into the shifter keeps the byte whole even when the
  // select rises in the same step as the last falling clock edge.
  always @(negedge i_sel_n) begin
    sh = i_reply;
    out_q = i_reply[7];
  end
  always @(posedge i_sck) if (!i_sel_n) sh = {sh[6:0], i_mosi};
  always @(negedge i_sck) if (!i_sel_n) out_q = sh[7];
  always @(posedge i_sel_n) o_got = sh;
  // A released line shows the inverse, so a stale bit never matches.
  assign o_miso = i_sel_n ? ~out_q : out_q;
endmodule // smc_peer

`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the serial core with a peer slave model.
// Assumes the register map of smc_defs.svh and a 100 MHz clock.
`include "smc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bench top
module tb_top;
  logic clk, resetn, wr_s, rd_s, sel_in, sel_w, mosi_w, miso_w, sck_w;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, reply, got, s;
  logic sck_o, sck_oe, mo, mo_oe, so, so_oe, ss_o, ss_oe, irq, prev, stop_d, stop_l;
  int fail_count, samples_checked, cyc, last, gap;

  // Pull-up on select and the master line, pull-down on the clock.
  assign sel_w = ss_oe ? sel_in : ss_o;
  assign mosi_w = mo_oe ? 1'b1 : mo;
  assign sck_w = sck_oe ? 1'b0 : sck_o;

  smc_core u_dut (.I_SYS_CLK(clk), .I_RESETN(resetn), .I_STOP_DEEP(stop_d),
    .I_STOP_LIGHT(stop_l), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
    .I_RD(rd_s), .O_RDATA(rdata), .O_IRQ(irq), .I_SERIAL_CLOCK_PIN(sck_w),
    .O_SERIAL_CLOCK_PIN(sck_o), .O_SERIAL_CLOCK_PIN_OE_N(sck_oe),
    .I_MASTER_SHARED_DATA_PIN(mosi_w), .O_MASTER_SHARED_DATA_PIN(mo),
    .O_MASTER_SHARED_DATA_PIN_OE_N(mo_oe), .I_SLAVE_SHARED_DATA_PIN(miso_w),
    .O_SLAVE_SHARED_DATA_PIN(so), .O_SLAVE_SHARED_DATA_PIN_OE_N(so_oe),
    .I_SELECT_PIN(sel_w), .O_SELECT_PIN(ss_o), .O_SELECT_PIN_OE_N(ss_oe));

  smc_peer u_peer (.i_sck(sck_w), .i_sel_n(sel_w), .i_mosi(mosi_w),
    .i_reply(reply), .o_miso(miso_w), .o_got(got));

  // Clock and a measure of the bit period seen on the clock pin.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev <= sck_o;
    if (sck_o && !prev) begin
      gap <= cyc - last;
      last <= cyc;
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  // Poll the receive-full flag, bounded so a stuck engine shows up.
  task automatic wait_rx;
    int n;
    n = 0;
    do begin
      rd(`SMC_ADDR_STATUS, s);
      n++;
    end while (s[7] !== 1'b1 && n < 300);
    chk("rxwait", 8'h01, {7'h0, s[7]});
  endtask

  // Reset values, an unmapped read, and all pins released.
  task automatic t_reset;
    logic [7:0] e [5] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd((i == 4) ? 3'h5 : 3'(i), s);
      chk("reg", e[i], s);
    end
    chk("oe", 8'h0F, {4'h0, sck_oe, mo_oe, so_oe, ss_oe});
  endtask

  // One master byte: peer byte, received byte and bit period.
  task automatic xfer(input logic [7:0] c1, b, tx, rp, ep, er, eg);
    wr(`SMC_ADDR_BAUD, b);
    wr(`SMC_ADDR_CTRL1, c1);
    reply = rp;
    rd(`SMC_ADDR_STATUS, s);
    wr(`SMC_ADDR_DATA, tx);
    chk("pins", 8'h01, {5'h0, sck_oe, mo_oe, so_oe});
    wait_rx();
    chk("peer", ep, got);
    chk("gap", eg, gap[7:0]);
    rd(`SMC_ADDR_DATA, s);
    chk("rx", er, s);
  endtask

  // Idle clock level follows the polarity bit; light stop releases and resumes.
  task automatic t_pol;
    wr(`SMC_ADDR_CTRL1, 8'h7A);
    repeat (3) @(posedge clk);
    chk("idle1", 8'h01, {7'h0, sck_o});
    chk("irq1", 8'h01, {7'h0, irq});
    stop_l <= 1'b1;
    repeat (3) @(posedge clk);
    chk("stop", 8'h0F, {4'h0, sck_oe, mo_oe, so_oe, ss_oe});
    stop_l <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake", 8'h01, {6'h0, sck_oe, sck_o});
    wr(`SMC_ADDR_CTRL1, 8'h52);
    repeat (3) @(posedge clk);
    chk("idle0", 8'h00, {7'h0, sck_o});
    chk("irq0", 8'h00, {7'h0, irq});
  endtask

  // Disable in mid-byte while a received byte is still pending.
  task automatic t_disable;
    int n;
    rd(`SMC_ADDR_STATUS, s);
    wr(`SMC_ADDR_DATA, 8'h5A);
    wait_rx();
    wr(`SMC_ADDR_DATA, 8'hC3);
    n = 0;
    while (sel_w !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("sel", 8'h00, {7'h0, sel_w});
    wr(`SMC_ADDR_CTRL1, 8'h10);
    rd(`SMC_ADDR_STATUS, s);
    chk("stat", 8'h20, s);
    chk("rel", 8'h0F, {4'h0, sck_oe, mo_oe, so_oe, ss_oe});
    // Select pulled low with the select output off is a mode fault.
    wr(`SMC_ADDR_CTRL1, 8'hD0);
    sel_in <= 1'b0;
    repeat (4) @(posedge clk);
    sel_in <= 1'b1;
    rd(`SMC_ADDR_STATUS, s);
    chk("mode_fault_flag", 8'h30, s);
    chk("irqf", 8'h01, {7'h0, irq});
  endtask

  // Slave role: clock is an input, slave line driven only when selected.
  task automatic t_slave;
    wr(`SMC_ADDR_CTRL1, 8'h40);
    rd(`SMC_ADDR_STATUS, s);
    wr(`SMC_ADDR_DATA, 8'h80);
    repeat (4) @(posedge clk);
    chk("unsel", 8'h01, {7'h0, so_oe});
    sel_in <= 1'b0;
    repeat (5) @(posedge clk);
    chk("slv", 8'h06, {5'h0, sck_oe, mo_oe, so_oe});
    chk("sdo", 8'h01, {7'h0, so});
    wr(`SMC_ADDR_CTRL2, 8'h01);
    repeat (2) @(posedge clk);
    chk("1w_in", 8'h01, {7'h0, so_oe});
    wr(`SMC_ADDR_CTRL2, 8'h09);
    repeat (2) @(posedge clk);
    chk("1w_out", 8'h02, {6'h0, mo_oe, so_oe});
    sel_in <= 1'b1;
    // Deep stop wakes the block in its reset state.
    stop_d <= 1'b1;
    @(posedge clk);
    stop_d <= 1'b0;
    rd(`SMC_ADDR_CTRL1, s);
    chk("deep", 8'h04, s);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  initial begin
    {resetn, wr_s, rd_s, addr, wdata, reply, stop_d, stop_l} = '0;
    {fail_count, samples_checked, cyc, last, gap} = '0;
    sel_in = 1'b1;
    prev = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    wr(`SMC_ADDR_CTRL2, 8'h10);
    wr(`SMC_ADDR_CTRL1, 8'h10);
    xfer(8'h52, 8'h21, 8'hA5, 8'h3C, 8'hA5, 8'h3C, 8'd12);
    xfer(8'h53, 8'h70, 8'h01, 8'h35, 8'h80, 8'hAC, 8'd16);
    t_pol();
    t_disable();
    t_slave();
    test_done();
  end
endmodule // tb_top

`default_nettype wire
